/* logic/lpmc_cfg.svh */
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
// Reduced clock rates applied in idle, in MHz.
`define LPMC_MEM_IDLE_MHZ 12'h10a
`define LPMC_AXI_IDLE_MHZ 12'h085
// Stopped clock rate.
`define LPMC_CLK_OFF_MHZ  12'h000
// Width of the clock rate outputs.
`define LPMC_MHZ_W        12
// Reset value of the latched target mode (run).
`define LPMC_TGT_RST      3'h5
`endif

/* logic/lpmc_pkg.sv */
package lpmc_pkg;
  typedef enum logic [2:0] {
    LPMC_OFF     = 3'h0,
    LPMC_BBM     = 3'h1,
    LPMC_LP_SUSP = 3'h2,
    LPMC_SUSP    = 3'h3,
    LPMC_IDLE    = 3'h4,
    LPMC_RUN     = 3'h5
  } lpmc_mode_e;

  typedef enum logic [1:0] {
    LPMC_LPS_RUN  = 2'h0,
    LPMC_LPS_WAIT = 2'h1,
    LPMC_LPS_STOP = 2'h2
  } lpmc_lps_e;

  typedef enum logic [2:0] {
    LPMC_S_RUN   = 3'h0,
    LPMC_S_SR    = 3'h1,
    LPMC_S_CLK   = 3'h2,
    LPMC_S_HOLD  = 3'h3,
    LPMC_S_WSTBY = 3'h4
  } lpmc_state_e;

  typedef enum logic [1:0] {
    LPMC_WK_RTC  = 2'h0,
    LPMC_WK_GPIO = 2'h1,
    LPMC_WK_USB  = 2'h2,
    LPMC_WK_OTH  = 2'h3
  } lpmc_wake_e;
endpackage

/* logic/lpmc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_ctrl #(
  parameter logic [`LPMC_MHZ_W-1:0] MEM_RUN_MHZ = 12'h190,
  parameter logic [`LPMC_MHZ_W-1:0] AXI_RUN_MHZ = 12'h0c8
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  input  wire logic                   enter_i,
  input  wire logic [2:0]             target_mode_i,
  input  wire logic                   sr_done_i,
  input  wire logic                   mem_pending_i,
  input  wire logic [3:0]             wake_i,
  output logic [1:0]                  low_power_setting_o,
  output logic                        lps_apply_o,
  output logic [`LPMC_MHZ_W-1:0]      mem_clk_mhz_o,
  output logic [`LPMC_MHZ_W-1:0]      axi_clk_mhz_o,
  output logic                        standby_request_out_o,
  output logic                        sr_cmd_o,
  output logic                        sr_auto_o,
  output logic                        battery_backed_io_rail_o,
  output logic                        core_rails_o,
  output logic                        ana_1v8_rails_o,
  output logic                        cpu_cluster_rail_o,
  output logic                        l3_on_o,
  output logic                        dram_ctrl_on_o,
  output logic                        system_pll_one_o,
  output logic                        xtal_on_o,
  output logic                        rtc_on_o,
  output logic                        wake_ack_o,
  output logic [2:0]                  mode_o
);

  lpmc_pkg::lpmc_state_e state;
  lpmc_pkg::lpmc_state_e next_state;
  lpmc_pkg::lpmc_mode_e  tgt;
  logic                  wake_ok;
  logic                  lp_mode;
  logic                  low_tgt;

  // Returns whether a wakeup source may end the given mode.
  function automatic logic wake_allowed(input lpmc_pkg::lpmc_mode_e m,
                                        input logic [3:0] w);
    logic ok;
    ok = 1'b0;
    case (m)
      lpmc_pkg::LPMC_IDLE: ok = |w;
      lpmc_pkg::LPMC_SUSP,
      lpmc_pkg::LPMC_LP_SUSP: ok = w[lpmc_pkg::LPMC_WK_RTC] |
                                   w[lpmc_pkg::LPMC_WK_GPIO];
      lpmc_pkg::LPMC_BBM: ok = w[lpmc_pkg::LPMC_WK_RTC];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  assign wake_ok = (state == lpmc_pkg::LPMC_S_HOLD) &&
                   wake_allowed(tgt, wake_i);
  assign low_tgt = (target_mode_i <= 3'(lpmc_pkg::LPMC_IDLE));
  assign lp_mode = (state == lpmc_pkg::LPMC_S_CLK) ||
                   (state == lpmc_pkg::LPMC_S_HOLD) ||
                   (state == lpmc_pkg::LPMC_S_WSTBY);

  // Latches the requested low-power mode on entry.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tgt <= lpmc_pkg::LPMC_RUN;
    end else if (state == lpmc_pkg::LPMC_S_RUN && enter_i && low_tgt) begin
      tgt <= lpmc_pkg::lpmc_mode_e'(target_mode_i);
    end else if (state == lpmc_pkg::LPMC_S_RUN) begin
      tgt <= lpmc_pkg::lpmc_mode_e'(`LPMC_TGT_RST);
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      lpmc_pkg::LPMC_S_RUN: begin
        if (enter_i && low_tgt) begin
          if (target_mode_i == 3'(lpmc_pkg::LPMC_SUSP) ||
              target_mode_i == 3'(lpmc_pkg::LPMC_LP_SUSP)) begin
            next_state = lpmc_pkg::LPMC_S_SR;
          end else begin
            next_state = lpmc_pkg::LPMC_S_CLK;
          end
        end
      end
      lpmc_pkg::LPMC_S_SR: begin
        if (sr_done_i) begin
          next_state = lpmc_pkg::LPMC_S_CLK;
        end
      end
      lpmc_pkg::LPMC_S_CLK: next_state = lpmc_pkg::LPMC_S_HOLD;
      lpmc_pkg::LPMC_S_HOLD: begin
        if (wake_ok) begin
          next_state = lpmc_pkg::LPMC_S_WSTBY;
        end
      end
      lpmc_pkg::LPMC_S_WSTBY: next_state = lpmc_pkg::LPMC_S_RUN;
      default: next_state = lpmc_pkg::LPMC_S_RUN;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= lpmc_pkg::LPMC_S_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Clock controller setting and clock rates.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_power_setting_o <= lpmc_pkg::LPMC_LPS_RUN;
      lps_apply_o         <= 1'b1;
      mem_clk_mhz_o       <= MEM_RUN_MHZ;
      axi_clk_mhz_o       <= AXI_RUN_MHZ;
    end else if (!lp_mode) begin
      low_power_setting_o <= lpmc_pkg::LPMC_LPS_RUN;
      lps_apply_o         <= 1'b1;
      mem_clk_mhz_o       <= MEM_RUN_MHZ;
      axi_clk_mhz_o       <= AXI_RUN_MHZ;
    end else if (tgt == lpmc_pkg::LPMC_IDLE) begin
      low_power_setting_o <= lpmc_pkg::LPMC_LPS_WAIT;
      lps_apply_o         <= 1'b1;
      mem_clk_mhz_o       <= `LPMC_MEM_IDLE_MHZ;
      axi_clk_mhz_o       <= `LPMC_AXI_IDLE_MHZ;
    end else begin
      low_power_setting_o <= lpmc_pkg::LPMC_LPS_STOP;
      lps_apply_o         <= (tgt == lpmc_pkg::LPMC_SUSP) ||
                             (tgt == lpmc_pkg::LPMC_LP_SUSP);
      mem_clk_mhz_o       <= `LPMC_CLK_OFF_MHZ;
      axi_clk_mhz_o       <= `LPMC_CLK_OFF_MHZ;
    end
  end

  // Self-refresh handling.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sr_cmd_o  <= 1'b0;
      sr_auto_o <= 1'b0;
    end else begin
      sr_cmd_o  <= (state == lpmc_pkg::LPMC_S_SR) ||
                   (lp_mode && tgt != lpmc_pkg::LPMC_IDLE &&
                    tgt != lpmc_pkg::LPMC_BBM &&
                    tgt != lpmc_pkg::LPMC_OFF);
      sr_auto_o <= lp_mode && tgt == lpmc_pkg::LPMC_IDLE &&
                   !mem_pending_i;
    end
  end

  // Standby request and rails, applied only once clocks are stopped.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      standby_request_out_o    <= 1'b0;
      battery_backed_io_rail_o <= 1'b1;
      core_rails_o             <= 1'b1;
      ana_1v8_rails_o          <= 1'b1;
      cpu_cluster_rail_o       <= 1'b1;
    end else if (state == lpmc_pkg::LPMC_S_HOLD && !wake_ok &&
                 tgt != lpmc_pkg::LPMC_IDLE) begin
      standby_request_out_o    <= 1'b1;
      battery_backed_io_rail_o <= (tgt != lpmc_pkg::LPMC_OFF);
      core_rails_o             <= (tgt == lpmc_pkg::LPMC_SUSP) ||
                                  (tgt == lpmc_pkg::LPMC_LP_SUSP);
      ana_1v8_rails_o          <= (tgt == lpmc_pkg::LPMC_SUSP);
      cpu_cluster_rail_o       <= 1'b0;
    end else begin
      standby_request_out_o    <= 1'b0;
      battery_backed_io_rail_o <= 1'b1;
      core_rails_o             <= 1'b1;
      ana_1v8_rails_o          <= 1'b1;
      cpu_cluster_rail_o       <= 1'b1;
    end
  end

  // Module power states and wakeup report.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      l3_on_o          <= 1'b1;
      dram_ctrl_on_o   <= 1'b1;
      system_pll_one_o <= 1'b1;
      xtal_on_o        <= 1'b1;
      rtc_on_o         <= 1'b1;
      wake_ack_o       <= 1'b0;
      mode_o           <= 3'(lpmc_pkg::LPMC_RUN);
    end else begin
      l3_on_o          <= !lp_mode || tgt == lpmc_pkg::LPMC_IDLE;
      dram_ctrl_on_o   <= !lp_mode || tgt == lpmc_pkg::LPMC_IDLE;
      system_pll_one_o <= !lp_mode || tgt == lpmc_pkg::LPMC_IDLE;
      xtal_on_o        <= !lp_mode || tgt == lpmc_pkg::LPMC_IDLE;
      rtc_on_o         <= !lp_mode || tgt != lpmc_pkg::LPMC_OFF;
      wake_ack_o       <= wake_ok;
      mode_o           <= lp_mode ? 3'(tgt) : 3'(lpmc_pkg::LPMC_RUN);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_idle_wait_setting: assert property (
    lp_mode && tgt == lpmc_pkg::LPMC_IDLE |=>
      low_power_setting_o == lpmc_pkg::LPMC_LPS_WAIT && lps_apply_o)
    else $error("idle did not apply wait setting");
  a_bbm_no_setting: assert property (
    lp_mode && tgt == lpmc_pkg::LPMC_BBM |=> !lps_apply_o)
    else $error("battery-backed applied a clock setting");
  a_idle_clock_rates: assert property (
    lp_mode && tgt == lpmc_pkg::LPMC_IDLE |=>
      mem_clk_mhz_o == 12'h10a && axi_clk_mhz_o == 12'h085)
    else $error("idle clock rates wrong");
  a_bbm_wake_filter: assert property (
    state == lpmc_pkg::LPMC_S_HOLD && tgt == lpmc_pkg::LPMC_BBM &&
    !wake_i[0] |=> state == lpmc_pkg::LPMC_S_HOLD)
    else $error("battery-backed woke on non-rtc source");
  a_auto_refresh: assert property (
    lp_mode && tgt == lpmc_pkg::LPMC_IDLE && !mem_pending_i |=> sr_auto_o)
    else $error("idle did not auto self-refresh");
  a_sr_before_stop: assert property (
    $rose(mem_clk_mhz_o == 12'h000) &&
    (tgt == lpmc_pkg::LPMC_SUSP || tgt == lpmc_pkg::LPMC_LP_SUSP) |->
      $past(sr_cmd_o, 1))
    else $error("clocks stopped before self-refresh");
  a_usb_ignored: assert property (
    state == lpmc_pkg::LPMC_S_HOLD && tgt == lpmc_pkg::LPMC_SUSP &&
    wake_i[2] && !wake_i[1] && !wake_i[0] |=>
      state == lpmc_pkg::LPMC_S_HOLD)
    else $error("usb wakeup honoured in suspend");
  a_standby_suspend: assert property (
    state == lpmc_pkg::LPMC_S_CLK && tgt == lpmc_pkg::LPMC_SUSP |=>
      ##1 standby_request_out_o && !ana_1v8_rails_o == 1'b0)
    else $error("suspend did not raise standby");
  a_lp_susp_rails: assert property (
    standby_request_out_o && mode_o == 3'h2 |-> !ana_1v8_rails_o &&
      core_rails_o && battery_backed_io_rail_o)
    else $error("low-power suspend rails wrong");
  a_suspend_domains: assert property (
    standby_request_out_o && mode_o == 3'h3 |-> !l3_on_o && !xtal_on_o &&
      !system_pll_one_o && rtc_on_o)
    else $error("suspend domains not off");
  a_wake_order: assert property (
    $fell(standby_request_out_o) |-> mem_clk_mhz_o == 12'h000 ##1
      mem_clk_mhz_o == 12'h000 ##1 mem_clk_mhz_o == MEM_RUN_MHZ)
    else $error("wake order broken");

  c_idle_cycle: cover property (
    state == lpmc_pkg::LPMC_S_HOLD && tgt == lpmc_pkg::LPMC_IDLE && wake_ok);
  c_suspend_cycle: cover property (
    $fell(standby_request_out_o) && mode_o == 3'h3);
  c_bbm_entry: cover property (
    standby_request_out_o && !core_rails_o);
endmodule
`default_nettype wire

/* testbench/lpmc_pmic_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lpmc_pmic_model (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic stby_i,
  output logic      usb_phy_o,
  output logic      cluster_o
);
  // Supplies follow the standby request one clock later.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      usb_phy_o <= 1'b1;
      cluster_o <= 1'b1;
    end else begin
      usb_phy_o <= !stby_i;
      cluster_o <= !stby_i;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_low_power_mode_controller.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lpmc_cfg.svh"
module tb_low_power_mode_controller;
  localparam logic [11:0] MRUN = 12'h190;
  localparam logic [11:0] ARUN = 12'h0c8;
  logic            clock_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            enter_i = 1'b0;
  logic [2:0]      tgt = 3'h5;
  logic            sr_done = 1'b0;
  logic            mem_pend = 1'b0;
  logic [3:0]      wake = 4'h0;
  wire logic [1:0] lps;
  wire logic       apply;
  wire logic [11:0] mclk;
  wire logic [11:0] aclk;
  wire logic       stby;
  wire logic       sr_cmd;
  wire logic       sr_auto;
  wire logic [3:0] rails;
  wire logic [4:0] dom;
  wire logic       ack;
  wire logic [2:0] mode;
  wire logic       usb_phy;
  wire logic       cluster;
  int              num_errors = 0;
  int              compares = 0;
  int              cyc = 0;

  always #2 clock_i = ~clock_i;

  lpmc_ctrl #(.MEM_RUN_MHZ(MRUN), .AXI_RUN_MHZ(ARUN)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .enter_i(enter_i),
    .target_mode_i(tgt), .sr_done_i(sr_done), .mem_pending_i(mem_pend),
    .wake_i(wake), .low_power_setting_o(lps), .lps_apply_o(apply),
    .mem_clk_mhz_o(mclk), .axi_clk_mhz_o(aclk),
    .standby_request_out_o(stby), .sr_cmd_o(sr_cmd), .sr_auto_o(sr_auto),
    .battery_backed_io_rail_o(rails[3]), .core_rails_o(rails[2]),
    .ana_1v8_rails_o(rails[1]), .cpu_cluster_rail_o(rails[0]),
    .l3_on_o(dom[4]), .dram_ctrl_on_o(dom[3]), .system_pll_one_o(dom[2]),
    .xtal_on_o(dom[1]), .rtc_on_o(dom[0]), .wake_ack_o(ack), .mode_o(mode));

  lpmc_pmic_model pmic (.clock_i(clock_i), .rst_i(rst_i), .stby_i(stby),
    .usb_phy_o(usb_phy), .cluster_o(cluster));

  task automatic tally_and_finish;
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic go(input logic [2:0] m);
    enter_i = 1'b1;
    tgt = m;
    step(1);
    enter_i = 1'b0;
  endtask

  task automatic wake_ok(input logic [3:0] w);
    int i;
    wake = w;
    i = 0;
    step(1);
    while (ack !== 1'b1 && i < 6) begin
      step(1);
      i++;
    end
    chk(ack, 12'h1);
    wake = 4'h0;
  endtask

  task automatic wake_no(input logic [3:0] w);
    wake = w;
    repeat (4) begin
      step(1);
      chk(ack, 12'h0);
    end
  endtask

  task automatic back_run;
    step(1);
    chk(stby, 12'h0);
    step(1);
    chk(mclk, MRUN);
    chk(aclk, ARUN);
    chk(mode, 12'h5);
  endtask

  task automatic t_idle;
    go(lpmc_pkg::LPMC_IDLE);
    step(2);
    chk(lps, lpmc_pkg::LPMC_LPS_WAIT);
    chk(apply, 12'h1);
    chk(mclk, `LPMC_MEM_IDLE_MHZ);
    chk(aclk, `LPMC_AXI_IDLE_MHZ);
    chk(dom, 12'h1f);
    chk(rails, 12'hf);
    chk(stby, 12'h0);
    mem_pend = 1'b1;
    step(2);
    chk(sr_auto, 12'h0);
    mem_pend = 1'b0;
    step(2);
    chk(sr_auto, 12'h1);
    for (int b = 0; b < 4; b++) begin
      if (b > 0) begin
        go(lpmc_pkg::LPMC_IDLE);
        step(2);
      end
      wake_ok(4'h1 << b);
      back_run;
    end
    $display("test idle done");
  endtask

  task automatic t_susp;
    go(lpmc_pkg::LPMC_SUSP);
    step(2);
    chk(sr_cmd, 12'h1);
    chk(mclk, MRUN);
    sr_done = 1'b1;
    step(2);
    chk(mclk, 12'h0);
    chk(aclk, 12'h0);
    chk(lps, lpmc_pkg::LPMC_LPS_STOP);
    chk(dom, 12'h01);
    chk(stby, 12'h0);
    step(1);
    chk(stby, 12'h1);
    chk(rails, 12'he);
    step(1);
    chk(usb_phy, 12'h0);
    chk(cluster, 12'h0);
    wake_no(4'hc);
    wake_ok(4'h2);
    chk(stby, 12'h0);
    chk(mclk, 12'h0);
    sr_done = 1'b0;
    back_run;
    $display("test suspend done");
  endtask

  task automatic t_lpsusp;
    go(lpmc_pkg::LPMC_LP_SUSP);
    step(2);
    chk(sr_cmd, 12'h1);
    sr_done = 1'b1;
    step(3);
    chk(rails, 12'hc);
    wake_ok(4'h2);
    sr_done = 1'b0;
    back_run;
    $display("test low power suspend done");
  endtask

  task automatic t_bbm;
    go(lpmc_pkg::LPMC_BBM);
    step(2);
    chk(apply, 12'h0);
    chk(mclk, 12'h0);
    chk(dom, 12'h01);
    step(1);
    chk(rails, 12'h8);
    wake_no(4'he);
    wake_ok(4'h1);
    back_run;
    $display("test battery backed done");
  endtask

  task automatic t_off;
    go(lpmc_pkg::LPMC_OFF);
    step(3);
    chk(rails, 12'h0);
    wake_no(4'h1);
    rst_i = 1'b1;
    step(1);
    rst_i = 1'b0;
    wake = 4'h0;
    step(1);
    chk(rails, 12'hf);
    chk(dom, 12'h1f);
    $display("test off done");
  endtask

  initial begin
    step(16);
    rst_i = 1'b0;
    step(1);
    t_idle;
    t_susp;
    t_lpsusp;
    t_bbm;
    t_off;
    tally_and_finish;
  end
endmodule
`default_nettype wire
